// ==== design/ieg_pkg.sv ====
// Package for the interrupt enable gating block: register map, bit positions,
// reset values and carrier types. Assumes a 32-bit AXI4-Lite register bus.
package ieg_pkg;

    // ----------------------------------------
    // Register map (word indices)
    // ----------------------------------------
    // Printed offsets are not all multiples of four, so they are indices
    localparam logic [7:0] IEG_IDX_ENABLE_PRIMARY = 8'hA8;
    localparam logic [7:0] IEG_IDX_ENABLE_SECONDARY = 8'hA9;
    localparam logic [7:0] IEG_IDX_PENDING_VIEW = 8'hC0;
    localparam logic [7:0] IEG_IDX_GATED_VIEW = 8'hC1;
    localparam logic [7:0] IEG_IDX_EVT_STATUS = 8'hC2;
    localparam logic [7:0] IEG_IDX_EVT_MASK = 8'hC3;
    localparam int IEG_ADDR_W = 12;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] IEG_RST_ENABLE_PRIMARY = 8'h00;
    localparam logic [7:0] IEG_RST_ENABLE_SECONDARY = 8'h00;
    localparam logic [1:0] IEG_RST_EVT_MASK = 2'h0;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int IEG_BIT_GLOBAL = 7;
    localparam int IEG_BIT_TIMER_TWO = 5;
    localparam int IEG_BIT_SERIAL_ONE = 4;
    localparam int IEG_BIT_TIMER_ONE = 3;
    localparam int IEG_BIT_EXT_B = 2;
    localparam int IEG_BIT_TIMER_ZERO = 1;
    localparam int IEG_BIT_EXT_A = 0;
    localparam int IEG_BIT_PWM = 7;
    localparam int IEG_BIT_TWO_WIRE = 6;
    localparam int IEG_BIT_SERIAL_TWO = 5;
    localparam int IEG_BIT_SERIAL_PERIPH = 4;
    localparam int IEG_BIT_CONV_TOUCH = 3;
    localparam int IEG_BIT_EXT_LOWVOLT = 2;
    localparam int IEG_BIT_PORT_ONE = 1;
    localparam int IEG_BIT_TIMER_THREE = 0;
    // Event status bits
    localparam int IEG_EVT_IRQ_RISE = 0;
    localparam int IEG_EVT_WAKE_RISE = 1;

    // ----------------------------------------
    // AXI response codes
    // ----------------------------------------
    localparam logic [1:0] IEG_RESP_OKAY = 2'h0;
    localparam logic [1:0] IEG_RESP_SLVERR = 2'h2;

    // ----------------------------------------
    // Carrier types
    // ----------------------------------------
    // Requests from sources, one level per line
    typedef struct packed {
        logic timer_zero;
        logic timer_one;
        logic timer_two;
        logic timer_three;
        logic serial_port_one;
        logic serial_port_two;
        logic serial_periph;
        logic two_wire;
        logic pwm_group;
        logic converter_touch;
        logic port_one_change;
        logic low_voltage_detect;
        logic ext_pin_a;
        logic ext_pin_b;
        logic [7:0] ext_pins_group;
    } ieg_src_t;

    // Pin requests that can wake from stop mode
    typedef struct packed {
        logic ext_pin_a;
        logic ext_pin_b;
        logic [7:0] ext_pins_group;
    } ieg_wake_t;

endpackage

// ==== design/ieg_top.sv ====
// Interrupt enable gating: global and per-source enables between the interrupt
// sources and the core, plus stop-mode wake gating for the external pins.
// Assumes sources give level requests on this clock; pins arrive asynchronously.
//
// How it works
// - Bit 7 of primary enable blocks every core request when 0, else per-source gating; stop-mode wake ignores it.
// - Primary bit 5 passes the second timer request.
// - Primary bit 4 passes the first serial port request.
// - Primary bit 3 passes the timer-one request.
// - Primary bit 2 passes pin B request and lets it wake from stop.
// - Primary bit 1 passes the timer-zero request.
// - Primary bit 0 passes pin A request and lets it wake from stop.
// - Secondary bit 7 passes the combined PWM request.
// - Secondary bit 6 passes the two-wire request, master or slave.
// - Secondary bit 5 passes the second serial port request.
// - Secondary bit 4 passes the serial peripheral request.
// - Secondary bit 3 passes the converter and touch request.
// - Secondary bit 2 passes pin group and low-voltage, and pin group wake.
// - Secondary bit 1 passes the port-one pin change request.
// - Secondary bit 0 passes the third timer request.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module ieg_top
    import ieg_pkg::*;
(
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RST_B,
    // AXI4-Lite write address
    input wire logic [IEG_ADDR_W-1:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    // AXI4-Lite write response
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    // AXI4-Lite read address
    input wire logic [IEG_ADDR_W-1:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    // AXI4-Lite read data
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    // Interrupt sources
    input wire ieg_src_t I_SRC,
    // Gated requests toward the core
    output ieg_src_t O_CORE_REQ,
    output logic O_CORE_ANY,
    // Stop-mode wake
    output logic O_WAKE,
    // Block event interrupt
    output logic O_IRQ
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Only the external pins are asynchronous; other sources share this clock
    ieg_wake_t pin_meta_r;
    ieg_wake_t pin_sync_r;
    ieg_src_t src;

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end else begin
            pin_meta_r <= {I_SRC.ext_pin_a, I_SRC.ext_pin_b, I_SRC.ext_pins_group};
            pin_sync_r <= pin_meta_r;
        end
    end

    always_comb begin
        src = I_SRC;
        src.ext_pin_a = pin_sync_r.ext_pin_a;
        src.ext_pin_b = pin_sync_r.ext_pin_b;
        src.ext_pins_group = pin_sync_r.ext_pins_group;
    end

    // ----------------------------------------
    // Enable, event status and event mask registers
    // ----------------------------------------
    logic [7:0] enable_primary_r;
    logic [7:0] enable_secondary_r;
    logic [1:0] evt_status_r;
    logic [1:0] evt_mask_r;

    // ----------------------------------------
    // AXI4-Lite write side
    // ----------------------------------------
    logic aw_held_r;
    logic w_held_r;
    logic [IEG_ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic w_lane0_r;
    logic wr_fire;
    logic [IEG_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_lane0;
    logic wr_hit;

    // Address and data are taken in either order; the write commits once both are held and no write response is pending
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end else if (I_AWVALID && O_AWREADY) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= I_AWADDR;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            w_held_r <= 1'b0;
            w_data_r <= '0;
            w_lane0_r <= 1'b0;
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end else if (I_WVALID && O_WREADY) begin
            w_held_r <= 1'b1;
            w_data_r <= I_WDATA;
            w_lane0_r <= I_WSTRB[0];
        end
    end

    assign wr_fire = aw_held_r && w_held_r && !O_BVALID;
    assign wr_addr = aw_addr_r;
    assign wr_data = w_data_r;
    assign wr_lane0 = w_lane0_r;

    always_comb begin
        case (wr_addr[IEG_ADDR_W-1:2])
            10'(IEG_IDX_ENABLE_PRIMARY),
            10'(IEG_IDX_ENABLE_SECONDARY),
            10'(IEG_IDX_PENDING_VIEW),
            10'(IEG_IDX_GATED_VIEW),
            10'(IEG_IDX_EVT_STATUS),
            10'(IEG_IDX_EVT_MASK): wr_hit = (wr_addr[1:0] == 2'h0);
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_AWREADY <= 1'b0;
            O_WREADY <= 1'b0;
        end else begin
            O_AWREADY <= !aw_held_r && !(I_AWVALID && O_AWREADY);
            O_WREADY <= !w_held_r && !(I_WVALID && O_WREADY);
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_BVALID <= 1'b0;
            O_BRESP <= IEG_RESP_OKAY;
        end else if (wr_fire) begin
            O_BVALID <= 1'b1;
            O_BRESP <= wr_hit ? IEG_RESP_OKAY : IEG_RESP_SLVERR;
        end else if (I_BREADY) begin
            O_BVALID <= 1'b0;
        end
    end

    logic wr_go;
    assign wr_go = wr_fire && wr_hit && wr_lane0;

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            enable_primary_r <= IEG_RST_ENABLE_PRIMARY;
            enable_secondary_r <= IEG_RST_ENABLE_SECONDARY;
            evt_mask_r <= IEG_RST_EVT_MASK;
        end else if (wr_go) begin
            case (wr_addr[IEG_ADDR_W-1:2])
                10'(IEG_IDX_ENABLE_PRIMARY): enable_primary_r <= wr_data[7:0] & 8'hBF;
                10'(IEG_IDX_ENABLE_SECONDARY): enable_secondary_r <= wr_data[7:0];
                10'(IEG_IDX_EVT_MASK): evt_mask_r <= wr_data[1:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Gating toward the core, and stop-mode wake gating
    // ----------------------------------------
    // Only the request is gated; pending flags live in the sources and survive
    ieg_src_t gated_nxt;
    ieg_wake_t wake_nxt;
    logic glob;

    always_comb begin
        glob = enable_primary_r[IEG_BIT_GLOBAL];
        gated_nxt = '0;
        gated_nxt.timer_two = glob && enable_primary_r[IEG_BIT_TIMER_TWO] && src.timer_two;
        gated_nxt.serial_port_one = glob && enable_primary_r[IEG_BIT_SERIAL_ONE] && src.serial_port_one;
        gated_nxt.timer_one = glob && enable_primary_r[IEG_BIT_TIMER_ONE] && src.timer_one;
        gated_nxt.ext_pin_b = glob && enable_primary_r[IEG_BIT_EXT_B] && src.ext_pin_b;
        gated_nxt.timer_zero = glob && enable_primary_r[IEG_BIT_TIMER_ZERO] && src.timer_zero;
        gated_nxt.ext_pin_a = glob && enable_primary_r[IEG_BIT_EXT_A] && src.ext_pin_a;
        gated_nxt.pwm_group = glob && enable_secondary_r[IEG_BIT_PWM] && src.pwm_group;
        gated_nxt.two_wire = glob && enable_secondary_r[IEG_BIT_TWO_WIRE] && src.two_wire;
        gated_nxt.serial_port_two = glob && enable_secondary_r[IEG_BIT_SERIAL_TWO] && src.serial_port_two;
        gated_nxt.serial_periph = glob && enable_secondary_r[IEG_BIT_SERIAL_PERIPH] && src.serial_periph;
        gated_nxt.converter_touch = glob && enable_secondary_r[IEG_BIT_CONV_TOUCH] && src.converter_touch;
        gated_nxt.ext_pins_group = {8{glob && enable_secondary_r[IEG_BIT_EXT_LOWVOLT]}} & src.ext_pins_group;
        gated_nxt.low_voltage_detect = glob && enable_secondary_r[IEG_BIT_EXT_LOWVOLT]
            && src.low_voltage_detect;
        gated_nxt.port_one_change = glob && enable_secondary_r[IEG_BIT_PORT_ONE] && src.port_one_change;
        gated_nxt.timer_three = glob && enable_secondary_r[IEG_BIT_TIMER_THREE] && src.timer_three;
        // Wake needs only the pin's own enable: the core is stopped, so the global bit is not consulted
        wake_nxt.ext_pin_a = enable_primary_r[IEG_BIT_EXT_A] && src.ext_pin_a;
        wake_nxt.ext_pin_b = enable_primary_r[IEG_BIT_EXT_B] && src.ext_pin_b;
        wake_nxt.ext_pins_group = {8{enable_secondary_r[IEG_BIT_EXT_LOWVOLT]}} & src.ext_pins_group;
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_CORE_REQ <= '0;
            O_CORE_ANY <= 1'b0;
            O_WAKE <= 1'b0;
        end else begin
            O_CORE_REQ <= gated_nxt;
            O_CORE_ANY <= |gated_nxt;
            O_WAKE <= |wake_nxt;
        end
    end

    // ----------------------------------------
    // Block events
    // ----------------------------------------
    logic any_prev_r;
    logic wake_prev_r;
    logic [1:0] evt_set;
    logic [1:0] evt_clr;

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            any_prev_r <= 1'b0;
            wake_prev_r <= 1'b0;
        end else begin
            any_prev_r <= |gated_nxt;
            wake_prev_r <= |wake_nxt;
        end
    end

    always_comb begin
        evt_set = '0;
        evt_set[IEG_EVT_IRQ_RISE] = (|gated_nxt) && !any_prev_r;
        evt_set[IEG_EVT_WAKE_RISE] = (|wake_nxt) && !wake_prev_r;
        evt_clr = '0;
        if (wr_go && wr_addr[IEG_ADDR_W-1:2] == 10'(IEG_IDX_EVT_STATUS)) begin
            evt_clr = wr_data[1:0];
        end
    end

    // Set wins over a same-cycle clear so no event is lost
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            evt_status_r <= '0;
            O_IRQ <= 1'b0;
        end else begin
            evt_status_r <= (evt_status_r & ~evt_clr) | evt_set;
            O_IRQ <= |(((evt_status_r & ~evt_clr) | evt_set) & evt_mask_r);
        end
    end

    // ----------------------------------------
    // AXI4-Lite read side
    // ----------------------------------------
    logic [31:0] rd_nxt;
    logic rd_hit;

    always_comb begin
        rd_nxt = '0;
        rd_hit = (I_ARADDR[1:0] == 2'h0);
        case (I_ARADDR[IEG_ADDR_W-1:2])
            10'(IEG_IDX_ENABLE_PRIMARY): rd_nxt[7:0] = enable_primary_r;
            10'(IEG_IDX_ENABLE_SECONDARY): rd_nxt[7:0] = enable_secondary_r;
            10'(IEG_IDX_PENDING_VIEW): rd_nxt[21:0] = src;
            10'(IEG_IDX_GATED_VIEW): rd_nxt[21:0] = O_CORE_REQ;
            10'(IEG_IDX_EVT_STATUS): rd_nxt[1:0] = evt_status_r;
            10'(IEG_IDX_EVT_MASK): rd_nxt[1:0] = evt_mask_r;
            default: rd_hit = 1'b0;
        endcase
        if (!rd_hit) begin
            rd_nxt = '0;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_ARREADY <= 1'b0;
            O_RVALID <= 1'b0;
            O_RDATA <= '0;
            O_RRESP <= IEG_RESP_OKAY;
        end else if (I_ARVALID && O_ARREADY) begin
            O_ARREADY <= 1'b0;
            O_RVALID <= 1'b1;
            O_RDATA <= rd_nxt;
            O_RRESP <= rd_hit ? IEG_RESP_OKAY : IEG_RESP_SLVERR;
        end else if (O_RVALID) begin
            if (I_RREADY) begin
                O_RVALID <= 1'b0;
                O_ARREADY <= 1'b1;
            end
        end else begin
            O_ARREADY <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// ==== bench/ieg_props.sv ====
// Checker for the enable gating block: shadows both enable registers from the
// write channels. Assumes writes take effect as the write response rises.
`timescale 1ns/10ps
`default_nettype none
module ieg_props
    import ieg_pkg::*;
(
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RST_B,
    // Write traffic
    input wire logic [IEG_ADDR_W-1:0] I_AWADDR,
    input wire logic I_AWVALID,
    input wire logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    input wire logic O_WREADY,
    input wire logic O_BVALID,
    // Requests
    input wire ieg_src_t I_SRC,
    input wire ieg_src_t O_CORE_REQ,
    input wire logic O_WAKE
);
    logic [IEG_ADDR_W-1:0] aw_r;
    logic [7:0] wd_r;
    logic [7:0] en_p;
    logic [7:0] en_s;
    logic ws_r;
    logic bv_r;
    logic [2:0] cnt_r;
    logic commit;
    logic steady;
    assign commit = O_BVALID && !bv_r && ws_r;
    assign steady = cnt_r > 3'h2;
    // ----------------
    // Enable shadow
    // ----------------
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            aw_r <= '0;
            wd_r <= '0;
            ws_r <= 1'b0;
            bv_r <= 1'b0;
        end else begin
            if (I_AWVALID && O_AWREADY) aw_r <= I_AWADDR;
            if (I_WVALID && O_WREADY) wd_r <= I_WDATA[7:0];
            if (I_WVALID && O_WREADY) ws_r <= I_WSTRB[0];
            bv_r <= O_BVALID;
        end
    end
    // Checks rest a few cycles after each commit, so latency skew cannot fire them
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            en_p <= IEG_RST_ENABLE_PRIMARY;
            en_s <= IEG_RST_ENABLE_SECONDARY;
            cnt_r <= '0;
        end else begin
            if (commit && aw_r == {2'h0, IEG_IDX_ENABLE_PRIMARY, 2'h0}) en_p <= wd_r;
            if (commit && aw_r == {2'h0, IEG_IDX_ENABLE_SECONDARY, 2'h0}) en_s <= wd_r;
            if (commit) cnt_r <= '0;
            else if (cnt_r != 3'h7) cnt_r <= cnt_r + 3'h1;
        end
    end
    // ----------------
    // Properties
    // ----------------
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RST_B);
    property p_g(logic en, logic src, logic req);
        steady |-> req == (en_p[7] && en && $past(src));
    endproperty
    property p_x(logic en, logic src, logic req);
        steady |-> req == (en_p[7] && en && $past(src, 3));
    endproperty
    sequence s_pin_a_held;
        (steady && en_p[0] && I_SRC.ext_pin_a) [*3];
    endsequence
    AST_GLOBAL: assert property (steady && !en_p[7] |-> O_CORE_REQ == '0) else $error("global off leak");
    AST_T2: assert property (p_g(en_p[5], I_SRC.timer_two, O_CORE_REQ.timer_two)) else $error("t2");
    AST_U1: assert property (p_g(en_p[4], I_SRC.serial_port_one, O_CORE_REQ.serial_port_one)) else $error("u1");
    AST_T1: assert property (p_g(en_p[3], I_SRC.timer_one, O_CORE_REQ.timer_one)) else $error("t1");
    AST_XB: assert property (p_x(en_p[2], I_SRC.ext_pin_b, O_CORE_REQ.ext_pin_b)) else $error("pin b");
    AST_T0: assert property (p_g(en_p[1], I_SRC.timer_zero, O_CORE_REQ.timer_zero)) else $error("t0");
    AST_XA: assert property (p_x(en_p[0], I_SRC.ext_pin_a, O_CORE_REQ.ext_pin_a)) else $error("pin a");
    AST_PWM: assert property (p_g(en_s[7], I_SRC.pwm_group, O_CORE_REQ.pwm_group)) else $error("pwm");
    AST_TW: assert property (p_g(en_s[6], I_SRC.two_wire, O_CORE_REQ.two_wire)) else $error("tw");
    AST_U2: assert property (p_g(en_s[5], I_SRC.serial_port_two, O_CORE_REQ.serial_port_two)) else $error("u2");
    AST_SP: assert property (p_g(en_s[4], I_SRC.serial_periph, O_CORE_REQ.serial_periph)) else $error("sp");
    AST_CT: assert property (p_g(en_s[3], I_SRC.converter_touch, O_CORE_REQ.converter_touch)) else $error("ct");
    AST_LV: assert property (p_g(en_s[2], I_SRC.low_voltage_detect, O_CORE_REQ.low_voltage_detect))
        else $error("lv");
    AST_GRP: assert property (steady |-> O_CORE_REQ.ext_pins_group ==
        ({8{en_p[7] && en_s[2]}} & $past(I_SRC.ext_pins_group, 3))) else $error("pin group");
    AST_P1: assert property (p_g(en_s[1], I_SRC.port_one_change, O_CORE_REQ.port_one_change)) else $error("p1");
    AST_T3: assert property (p_g(en_s[0], I_SRC.timer_three, O_CORE_REQ.timer_three)) else $error("t3");
    AST_WAKE_ON: assert property (s_pin_a_held |=> O_WAKE) else $error("no wake");
    AST_WAKE_OFF: assert property (steady && !en_p[0] && !en_p[2] && !en_s[2] |-> !O_WAKE)
        else $error("stray wake");
endmodule
bind ieg_top ieg_props u_props (
    .I_CLOCK(I_CLOCK), .I_RST_B(I_RST_B), .I_AWADDR(I_AWADDR), .I_AWVALID(I_AWVALID),
    .O_AWREADY(O_AWREADY), .I_WDATA(I_WDATA), .I_WSTRB(I_WSTRB), .I_WVALID(I_WVALID),
    .O_WREADY(O_WREADY), .O_BVALID(O_BVALID), .I_SRC(I_SRC), .O_CORE_REQ(O_CORE_REQ), .O_WAKE(O_WAKE)
);
`default_nettype wire

// ==== bench/ieg_src_model.sv ====
// Far-side model: interrupt sources with sticky pending flags.
// Assumes the bench pulses set and clear for one clock at a time.
`timescale 1ns/10ps
`default_nettype none
module ieg_src_model
    import ieg_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Flag control
    input wire ieg_src_t i_set,
    input wire ieg_src_t i_clr,
    // Requests toward the block
    output ieg_src_t o_pend
);
    // Only servicing clears a flag; masking downstream leaves it pending
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pend <= '0;
        end else begin
            o_pend <= (o_pend & ~i_clr) | i_set;
        end
    end
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Testbench for the enable gating block: register tasks, queued expectations.
// Assumes map and field order from ieg_pkg.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module tb_top
    import ieg_pkg::*;
;
    logic clk = 0;
    logic rst_b = 0;
    logic [11:0] awaddr = '0;
    logic [11:0] araddr = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic [1:0] bresp, rresp, y;
    logic [31:0] rdata;
    logic [33:0] x;
    logic awready, wready, bvalid, arready, rvalid, any, wake, irq;
    ieg_src_t s_set = '0, s_clr = '0, pend, core;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [31:0] seed = 32'h1C;
    int err_count = 0, samples_checked = 0;
    ieg_top dut (.I_CLOCK(clk), .I_RST_B(rst_b), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
        .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
        .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
        .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_SRC(pend),
        .O_CORE_REQ(core), .O_CORE_ANY(any), .O_WAKE(wake), .O_IRQ(irq));
    ieg_src_model u_src (.i_clk(clk), .i_rst_b(rst_b), .i_set(s_set), .i_clr(s_clr), .o_pend(pend));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic ieg_src_t gate(input logic [7:0] p, input logic [7:0] s, input ieg_src_t v);
        ieg_src_t m;
        m = {p[1], p[3], p[5], s[0], p[4], s[5], s[4], s[6], s[7], s[3], s[1], s[2], p[0], p[2], {8{s[2]}}};
        return p[7] ? (v & m) : '0;
    endfunction
    // No cycle limit here: the watchdog alone ends a wait that never completes
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic s, input logic [1:0] e);
        bq.push_back(e);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= {3'h0, s};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [1:0] r, input logic [31:0] e);
        rq.push_back({r, e});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask
    task automatic src(input ieg_src_t v);
        @(posedge clk);
        s_set <= v;
        s_clr <= ~v;
        @(posedge clk);
        s_set <= '0;
        s_clr <= '0;
    endtask
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        if (rvalid && rready && rq.size() > 0) begin
            x = rq.pop_front();
            `CHK({rresp, rdata}, x)
        end
        if (bvalid && bready && bq.size() > 0) begin
            y = bq.pop_front();
            `CHK(bresp, y)
        end
    end
    initial forever #10 clk = ~clk;
    initial begin
        #(20 * 5000);
        err_count++;
        close_out();
    end
    initial begin
        logic [31:0] r;
        logic [7:0] p, s;
        ieg_src_t v;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        rd(12'h2A0, 2'h0, 32'h0);
        rd(12'h2A4, 2'h0, 32'h0);
        rd(12'h2A8, 2'h2, 32'h0);
        wr(12'h2A1, 8'hFF, 1'b1, 2'h2);
        wr(12'h2A0, 8'hFF, 1'b0, 2'h0);
        rd(12'h2A0, 2'h0, 32'h0);
        for (int i = 0; i < 14; i++) begin
            r = xs();
            p = r[7:0];
            s = r[15:8];
            r = xs();
            v = r[21:0];
            wr(12'h2A0, p, 1'b1, 2'h0);
            wr(12'h2A4, s, 1'b1, 2'h0);
            src(v);
            repeat (5) @(posedge clk);
            `CHK(any, |gate(p, s, v))
            rd(12'h304, 2'h0, {10'h0, gate(p, s, v)});
            rd(12'h300, 2'h0, {10'h0, v});
            rd(12'h2A4, 2'h0, {24'h0, s});
        end
        src(22'h20_0000);
        wr(12'h2A0, 8'h80, 1'b1, 2'h0);
        rd(12'h300, 2'h0, 32'h20_0000);
        rd(12'h304, 2'h0, 32'h0);
        wr(12'h2A0, 8'h82, 1'b1, 2'h0);
        rd(12'h304, 2'h0, 32'h20_0000);
        wr(12'h30C, 8'h00, 1'b1, 2'h0);
        src('0);
        wr(12'h308, 8'h03, 1'b1, 2'h0);
        rd(12'h308, 2'h0, 32'h0);
        src(22'h20_0000);
        repeat (4) @(posedge clk);
        rd(12'h308, 2'h0, 32'h1);
        `CHK(irq, 1'b0)
        wr(12'h30C, 8'h01, 1'b1, 2'h0);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1)
        wr(12'h308, 8'h01, 1'b1, 2'h0);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        rd(12'h308, 2'h0, 32'h0);
        wr(12'h2A0, 8'h01, 1'b1, 2'h0);
        src(22'h200);
        repeat (5) @(posedge clk);
        `CHK(wake, 1'b1)
        `CHK(any, 1'b0)
        // Wake rise sets status bit 1; the read also lets the wake assertion finish
        rd(12'h308, 2'h0, 32'h2);
        close_out();
    end
endmodule
`default_nettype wire
